// ---- i2c_slave_sleep_control_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_sleep_control_tb_top;
	import tse_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, scl, sda_drv, sda_out, sda_oe_n, reg_wr, reg_cmd, reg_rd;
	logic cfg_addr_we = 1'b0, cfg_lock_set = 1'b0, cfg_slp_en = 1'b0, cfg_bidir = 1'b0, button_press = 1'b0;
	logic [6:0] cfg_addr = 7'h00, own_addr;
	logic [1:0] cfg_mode = 2'h0, cfg_ivl = 2'h0;
	logic [2:0] cfg_slp_pin = 3'h0;
	logic [5:0] gpio_drv = 6'h3e, cfg_wake_mask = 6'h00, gpio_out, gpio_oe_n, gpio_free;
	logic [7:0] reg_rdata = 8'hc3, reg_wdata, r, cmd_b, wr_b;
	logic addr_locked, awake, sense_on, scan_req, a;
	tse_mode_t pwr_mode;
	int n_mismatch = 0, num_checks = 0, ncmd = 0, nwr = 0, nrd = 0, n;
	// Pull-ups on every open-drain line
	wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
	wire logic [5:0] gpio_in = gpio_drv & (gpio_oe_n | gpio_out);
	tse_host_bfm h (.ref_clk, .sda(sda_line), .scl, .sda_drv);
	tse_ctrl #(.IVL0_CYC(20), .IVL1_CYC(40), .IVL2_CYC(60), .IVL3_CYC(80)) dut (.ref_clk, .rst, .scl_in(scl),
		.sda_in(sda_line), .sda_out, .sda_oe_n, .gpio_in, .gpio_out, .gpio_oe_n, .gpio_free, .cfg_addr,
		.cfg_addr_we, .cfg_lock_set, .cfg_mode, .cfg_ivl, .cfg_slp_en, .cfg_slp_pin, .cfg_bidir, .cfg_wake_mask,
		.button_press, .reg_rdata, .reg_wr, .reg_cmd, .reg_rd, .reg_wdata, .own_addr, .addr_locked, .pwr_mode,
		.awake, .sense_on, .scan_req);
	initial
		forever #2 ref_clk = ~ref_clk;
	// Count and capture core pulses
	always @(posedge ref_clk)
	begin
		ncmd += int'(reg_cmd === 1'b1);
		nwr += int'(reg_wr === 1'b1);
		nrd += int'(reg_rd === 1'b1);
		if (reg_cmd === 1'b1)
			cmd_b = reg_wdata;
		if (reg_wr === 1'b1)
			wr_b = reg_wdata;
	end
	task automatic tk(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait on scan pulse or awake
	task automatic wt(input bit scan, input int lim);
		n = 0;
		while ((scan ? scan_req : awake) !== 1'b1 && n < lim)
		begin
			tk(1);
			n++;
		end
		if (n == lim)
		begin
			chk("wait", 8'h01, 8'h00);
			tally_and_finish;
		end
	endtask
	task automatic reset_dut;
		rst = 1'b1;
		tk(20);
		rst = 1'b0;
		tk(1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		chk("run time", 8'h00, 8'h01);
		tally_and_finish;
	end
	initial
	begin
		reset_dut;
		chk("own_addr", 8'h00, {1'b0, own_addr});
		chk("lock", 8'h00, {7'h00, addr_locked});
		chk("mode", 8'h00, {6'h00, pwr_mode});
		chk("free", 8'h3f, {2'h0, gpio_free});
		$display("reset test done");
		cfg_addr = 7'h4b;
		cfg_addr_we = 1'b1;
		tk(1);
		cfg_addr_we = 1'b0;
		tk(1);
		chk("own_addr", 8'h4b, {1'b0, own_addr});
		h.start;
		h.byte_io(8'h96, 1'b1, r, a);
		chk("write ack", 8'h00, {7'h00, a});
		h.byte_io(8'h5a, 1'b1, r, a);
		h.byte_io(8'ha5, 1'b1, r, a);
		h.start;
		h.byte_io(8'h97, 1'b1, r, a);
		chk("read ack", 8'h00, {7'h00, a});
		h.byte_io(8'hff, 1'b1, r, a);
		h.stop;
		chk("read data", 8'hc3, r);
		chk("command", 8'h5a, cmd_b);
		chk("write data", 8'ha5, wr_b);
		chk("pulses", 8'h51, {ncmd[1:0], nwr[1:0], nrd[3:0]});
		$display("transfer test done");
		cfg_lock_set = 1'b1;
		tk(1);
		cfg_lock_set = 1'b0;
		cfg_addr = 7'h7f;
		cfg_addr_we = 1'b1;
		tk(1);
		cfg_addr_we = 1'b0;
		tk(1);
		chk("locked addr", 8'h4b, {1'b0, own_addr});
		// Neither the old reset address nor the refused one may answer
		for (int i = 0; i < 3; i++)
		begin
			h.start;
			h.byte_io(i == 0 ? 8'h01 : (i == 1 ? 8'h14 : 8'hfe), 1'b1, r, a);
			h.stop;
			chk("foreign nack", 8'h01, {7'h00, a});
		end
		$display("address test done");
		cfg_mode = 2'h1;
		for (int i = 0; i < 4; i++)
		begin
			cfg_ivl = 2'(i);
			wt(1'b1, 400);
			tk(1);
			wt(1'b1, 400);
			chk("gap", 8'h01, {7'h00, n >= 20 * (i + 1) - 3 && n <= 40 * (i + 1)});
		end
		tk(5);
		chk("asleep", 8'h00, {7'h00, awake});
		gpio_drv[0] = 1'b1;
		cfg_wake_mask = 6'h01;
		wt(1'b0, 10);
		$display("sleep test done");
		cfg_wake_mask = 6'h00;
		gpio_drv[0] = 1'b0;
		cfg_mode = 2'h2;
		reset_dut;
		tk(10);
		n = 0;
		repeat (300)
		begin
			n += int'(scan_req === 1'b1);
			tk(1);
		end
		chk("deep scans", 8'h00, n[7:0]);
		chk("deep awake", 8'h00, {7'h00, awake});
		gpio_drv[0] = 1'b1;
		cfg_wake_mask = 6'h01;
		wt(1'b0, 10);
		$display("deep test done");
		cfg_wake_mask = 6'h00;
		cfg_mode = 2'h1;
		reset_dut;
		cfg_slp_en = 1'b1;
		cfg_slp_pin = 3'h2;
		tk(3);
		chk("free", 8'h3b, {2'h0, gpio_free});
		gpio_drv[2] = 1'b0;
		wt(1'b0, 20);
		gpio_drv[2] = 1'b1;
		cfg_bidir = 1'b1;
		button_press = 1'b1;
		tk(3);
		chk("press out", 8'h00, {7'h00, gpio_oe_n[2]});
		button_press = 1'b0;
		$display("sleep pin test done");
		for (int i = 3; i >= 0; i--)
		begin
			cfg_mode = 2'(i);
			tk(4);
			chk("mode", 8'(i == 3 ? 0 : i), {6'h00, pwr_mode});
		end
		chk("sense", 8'h01, {7'h00, sense_on});
		$display("mode test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ---- tse_bus_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Byte-level traffic between the two-wire engine and the control core
interface tse_bus_if;
	logic start;
	logic stop;
	logic byte_vld;
	logic [7:0] rx_byte;
	logic addr_hit;
	logic rd_dir;
	logic first;
	logic [7:0] tx_byte;
	logic [6:0] own_addr;
	modport eng (output start, stop, byte_vld, rx_byte, addr_hit, rd_dir, first, input tx_byte, own_addr);
	modport core (input start, stop, byte_vld, rx_byte, addr_hit, rd_dir, first, output tx_byte, own_addr);
endinterface
`default_nettype wire

// ---- tse_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module tse_ctrl
	import tse_pkg::*;
#(
	parameter int IVL0_CYC = TSE_IVL0_CYC,
	parameter int IVL1_CYC = TSE_IVL1_CYC,
	parameter int IVL2_CYC = TSE_IVL2_CYC,
	parameter int IVL3_CYC = TSE_IVL3_CYC
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [TSE_GPIO_N-1:0] gpio_in,
	output logic [TSE_GPIO_N-1:0] gpio_out,
	output logic [TSE_GPIO_N-1:0] gpio_oe_n,
	output logic [TSE_GPIO_N-1:0] gpio_free,
	input wire logic [6:0] cfg_addr,
	input wire logic cfg_addr_we,
	input wire logic cfg_lock_set,
	input wire logic [1:0] cfg_mode,
	input wire logic [1:0] cfg_ivl,
	input wire logic cfg_slp_en,
	input wire logic [2:0] cfg_slp_pin,
	input wire logic cfg_bidir,
	input wire logic [TSE_GPIO_N-1:0] cfg_wake_mask,
	input wire logic button_press,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_cmd,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	output logic [6:0] own_addr,
	output logic addr_locked,
	output var tse_pkg::tse_mode_t pwr_mode,
	output logic awake,
	output logic sense_on,
	output logic scan_req
);
	import tse_pkg::*;
	tse_bus_if bus ();
	typedef struct packed {
		logic [6:0] addr;
		logic lock;
		tse_mode_t mode;
		logic awake;
		logic [TSE_TMR_W-1:0] tmr;
		logic scan;
		logic [1:0] idx;
		logic wr;
		logic cmd;
		logic rd;
		logic [7:0] wdata;
		logic irq;
		logic [TSE_GPIO_N-1:0] free;
		logic [TSE_GPIO_N-1:0] oe_n;
	} tse_core_t;
	tse_core_t c_r, c_nxt;
	logic [TSE_TMR_W-1:0] ivl_cyc;
	logic gpio_wake, host_wake, slp_pin_lvl;
	// Interval lookup
	always_comb
	begin
		unique case (cfg_ivl)
			TSE_IVL_1MS95: ivl_cyc = TSE_TMR_W'(IVL0_CYC);
			TSE_IVL_15MS6: ivl_cyc = TSE_TMR_W'(IVL1_CYC);
			TSE_IVL_125MS: ivl_cyc = TSE_TMR_W'(IVL2_CYC);
			TSE_IVL_1S: ivl_cyc = TSE_TMR_W'(IVL3_CYC);
		endcase
	end
	// Wake sources; control pin is active low
	assign slp_pin_lvl = gpio_in[cfg_slp_pin];
	assign host_wake = cfg_slp_en & ~slp_pin_lvl;
	assign gpio_wake = |(gpio_in & cfg_wake_mask & ~(cfg_slp_en ? (6'h01 << cfg_slp_pin) : 6'h00));
	assign bus.own_addr = c_r.addr;
	assign bus.tx_byte = reg_rdata;
	// Core next state
	always_comb
	begin
		c_nxt = c_r;
		c_nxt.scan = 1'b0;
		c_nxt.wr = 1'b0;
		c_nxt.cmd = 1'b0;
		c_nxt.rd = 1'b0;
		// Address only changes while unlocked; lock is sticky
		if (cfg_addr_we && !c_r.lock)
			c_nxt.addr = cfg_addr;
		if (cfg_lock_set)
			c_nxt.lock = 1'b1;
		c_nxt.mode = tse_mode_t'(cfg_mode == 2'h3 ? 2'h0 : cfg_mode);
		// Register writes: first data byte is the command/offset, rest data
		if (bus.byte_vld && !bus.first && bus.addr_hit && !bus.rd_dir)
		begin
			c_nxt.wdata = bus.rx_byte;
			c_nxt.cmd = (c_r.idx == 2'h0);
			c_nxt.wr = (c_r.idx != 2'h0);
			c_nxt.idx = 2'h1;
		end
		if (bus.byte_vld && bus.first && bus.addr_hit && bus.rd_dir)
			c_nxt.rd = 1'b1;
		if (bus.start)
			c_nxt.idx = 2'h0;
		// Power sequencing
		unique case (c_r.mode)
			TSE_MODE_ACTIVE: c_nxt.awake = 1'b1;
			TSE_MODE_SLEEP:
			begin
				if (c_r.tmr >= ivl_cyc - 1'b1)
				begin
					c_nxt.tmr = '0;
					c_nxt.scan = 1'b1;
				end
				else
					c_nxt.tmr = c_r.tmr + 1'b1;
				// Stay awake while host holds the control pin or on GPIO
				c_nxt.awake = host_wake | gpio_wake | (c_r.tmr >= ivl_cyc - 1'b1);
			end
			TSE_MODE_DEEP:
			begin
				c_nxt.tmr = '0;
				c_nxt.awake = host_wake | gpio_wake;
			end
			default: c_nxt.awake = 1'b1;
		endcase
		if (c_r.mode != TSE_MODE_SLEEP)
			c_nxt.tmr = '0;
		// Awake must arrive with the mode, or active would show a dark cycle
		if (c_nxt.mode == TSE_MODE_ACTIVE)
			c_nxt.awake = 1'b1;
		// Press indication on the control pin, only if bidirectional
		c_nxt.irq = cfg_slp_en & cfg_bidir & button_press;
		c_nxt.oe_n = ~((cfg_slp_en & cfg_bidir & button_press) ? (6'h01 << cfg_slp_pin) : 6'h00);
		c_nxt.free = ~(cfg_slp_en ? (6'h01 << cfg_slp_pin) : 6'h00);
	end
	// Register, reset to active with lock clear
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			c_r <= '{addr: TSE_ADDR_RST, lock: 1'b0, mode: TSE_MODE_ACTIVE, awake: 1'b1, free: '1, oe_n: '1,
				default: '0};
		else
			c_r <= c_nxt;
	end
	// Bus engine; works at any host rate well below ref_clk
	tse_twi_slave u_twi (
		.ref_clk(ref_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.bus(bus)
	);
	// Outputs straight from flops, except gpio_out tied low
	assign gpio_out = '0;
	assign gpio_oe_n = c_r.oe_n;
	assign gpio_free = c_r.free;
	assign reg_wr = c_r.wr;
	assign reg_cmd = c_r.cmd;
	assign reg_rd = c_r.rd;
	assign reg_wdata = c_r.wdata;
	assign own_addr = c_r.addr;
	assign addr_locked = c_r.lock;
	assign pwr_mode = c_r.mode;
	assign awake = c_r.awake;
	assign sense_on = c_r.awake;
	assign scan_req = c_r.scan;
endmodule
`default_nettype wire

// ---- tse_ctrl_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// Port-level watch on the control core
module tse_ctrl_chk
	import tse_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [TSE_GPIO_N-1:0] gpio_oe_n,
	input wire logic [TSE_GPIO_N-1:0] gpio_free,
	input wire logic [6:0] cfg_addr,
	input wire logic cfg_addr_we,
	input wire logic cfg_lock_set,
	input wire logic cfg_slp_en,
	input wire logic [2:0] cfg_slp_pin,
	input wire logic cfg_bidir,
	input wire logic [6:0] own_addr,
	input wire logic addr_locked,
	input wire tse_pkg::tse_mode_t pwr_mode,
	input wire logic awake,
	input wire logic sense_on,
	input wire logic scan_req
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Load asked while free, lock not racing it
	sequence s_load;
		cfg_addr_we && !addr_locked && !cfg_lock_set;
	endsequence
	// Sleep pin claimed and steady for two cycles
	sequence s_pin_held;
		(cfg_slp_en && $stable(cfg_slp_pin))[*2];
	endsequence
	a_addr_load: assert property (s_load |=> own_addr == $past(cfg_addr))
		else $error("address load missed");
	a_lock_freeze: assert property (addr_locked |=> addr_locked && $stable(own_addr))
		else $error("locked address moved");
	a_lock_set: assert property (cfg_lock_set |=> addr_locked)
		else $error("lock not taken");
	a_reset_state: assert property ($fell(rst) |-> pwr_mode == TSE_MODE_ACTIVE && !addr_locked)
		else $error("bad state after reset");
	a_active_powered: assert property (pwr_mode == TSE_MODE_ACTIVE |-> awake && sense_on)
		else $error("active mode not powered");
	a_deep_no_scan: assert property (pwr_mode == TSE_MODE_DEEP && !awake |-> !scan_req)
		else $error("scan in deep sleep");
	a_pin_taken: assert property (s_pin_held |-> !gpio_free[cfg_slp_pin])
		else $error("sleep pin still free");
	a_no_press_out: assert property (!cfg_bidir [*2] |-> &gpio_oe_n)
		else $error("pin pulled without option");
endmodule
bind tse_ctrl tse_ctrl_chk u_chk (.ref_clk, .rst, .gpio_oe_n, .gpio_free, .cfg_addr, .cfg_addr_we, .cfg_lock_set,
	.cfg_slp_en, .cfg_slp_pin, .cfg_bidir, .own_addr, .addr_locked, .pwr_mode, .awake, .sense_on, .scan_req);
`default_nettype wire

// ---- tse_host_bfm.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bus master model; half period shortened from 400 kHz to keep runs brief
module tse_host_bfm #(
	parameter int HALF = 5
)
(
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// One bit: data set while clock low, sampled at end of high phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		tk(HALF);
		scl = 1'b1;
		tk(HALF);
		r = sda;
		scl = 1'b0;
	endtask
	// Also serves as repeated start
	task automatic start;
		sda_drv = 1'b1;
		tk(HALF);
		scl = 1'b1;
		tk(HALF);
		sda_drv = 1'b0;
		tk(HALF);
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		tk(HALF);
		scl = 1'b1;
		tk(HALF);
		sda_drv = 1'b1;
		tk(HALF);
	endtask
	// Eight bits msb first, then the ninth; ones release the line
	task automatic byte_io(input logic [7:0] w, input logic m, output logic [7:0] r, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(m, ak);
	endtask
endmodule
`default_nettype wire

// ---- tse_pkg.sv ----
package tse_pkg;
	// Power modes
	typedef enum logic [1:0] {TSE_MODE_ACTIVE, TSE_MODE_SLEEP, TSE_MODE_DEEP} tse_mode_t;
	// Wake interval selections
	localparam logic [1:0] TSE_IVL_1MS95 = 2'h0;
	localparam logic [1:0] TSE_IVL_15MS6 = 2'h1;
	localparam logic [1:0] TSE_IVL_125MS = 2'h2;
	localparam logic [1:0] TSE_IVL_1S = 2'h3;
	// Interval times in microseconds, as printed
	localparam real TSE_IVL0_US = 1950.0;
	localparam real TSE_IVL1_US = 15600.0;
	localparam real TSE_IVL2_US = 125000.0;
	localparam real TSE_IVL3_US = 1000000.0;
	localparam real TSE_CLK_MHZ = 250.0;
	// All times round down
	localparam int TSE_IVL0_CYC = int'($floor(TSE_IVL0_US * TSE_CLK_MHZ));
	localparam int TSE_IVL1_CYC = int'($floor(TSE_IVL1_US * TSE_CLK_MHZ));
	localparam int TSE_IVL2_CYC = int'($floor(TSE_IVL2_US * TSE_CLK_MHZ));
	localparam int TSE_IVL3_CYC = int'($floor(TSE_IVL3_US * TSE_CLK_MHZ));
	localparam int TSE_TMR_W = 28;
	// Address byte layout
	localparam int TSE_ADDR_W = 7;
	localparam int TSE_RW_BIT = 0;
	localparam logic TSE_RW_WRITE = 1'b0;
	localparam logic TSE_RW_READ = 1'b1;
	// Reset values and GPIO count
	localparam logic [6:0] TSE_ADDR_RST = 7'h00;
	localparam int TSE_GPIO_N = 6;
endpackage

// ---- tse_twi_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bit engine of the two-wire slave; lines sampled on ref_clk
module tse_twi_slave
	import tse_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	tse_bus_if.eng bus
);
	typedef enum logic [2:0] {TS_IDLE, TS_RECV, TS_ACK, TS_SEND, TS_RACK} tse_ts_t;
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		tse_ts_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic first;
		logic rd;
		logic drv;
		logic start;
		logic stop;
		logic vld;
		logic hit;
	} tse_tw_t;
	tse_tw_t s_r, s_nxt;
	logic rise, fall;
	assign rise = scl_in & ~s_r.scl_q;
	assign fall = ~scl_in & s_r.scl_q;
	// Next-state logic; start and stop win over bit handling
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.scl_q = scl_in;
		s_nxt.sda_q = sda_in;
		s_nxt.start = 1'b0;
		s_nxt.stop = 1'b0;
		s_nxt.vld = 1'b0;
		if (s_r.scl_q && scl_in && s_r.sda_q && !sda_in)
		begin
			s_nxt.st = TS_RECV;
			s_nxt.cnt = 4'h0;
			s_nxt.first = 1'b1;
			s_nxt.hit = 1'b0;
			s_nxt.drv = 1'b0;
			s_nxt.start = 1'b1;
		end
		else if (s_r.scl_q && scl_in && !s_r.sda_q && sda_in)
		begin
			s_nxt.st = TS_IDLE;
			s_nxt.drv = 1'b0;
			s_nxt.stop = 1'b1;
		end
		else
		begin
			unique case (s_r.st)
				TS_IDLE: ;
				TS_RECV:
					if (rise)
					begin
						s_nxt.sh = {s_r.sh[6:0], sda_in};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end
					else if (fall && s_r.cnt == 4'h8)
					begin
						s_nxt.vld = 1'b1;
						s_nxt.cnt = 4'h0;
						if (s_r.first)
						begin
							// Upper seven bits are the address, bit 0 the direction
							s_nxt.rd = (s_r.sh[TSE_RW_BIT] == TSE_RW_READ);
							s_nxt.hit = (s_r.sh[7:1] == bus.own_addr);
						end
						// Foreign address: never touch the bus
						s_nxt.drv = s_r.first ? (s_r.sh[7:1] == bus.own_addr) : s_r.hit;
						s_nxt.st = (s_r.first ? (s_r.sh[7:1] == bus.own_addr) : s_r.hit) ? TS_ACK : TS_IDLE;
					end
				TS_ACK:
					if (fall)
					begin
						s_nxt.first = 1'b0;
						s_nxt.cnt = 4'h0;
						if (s_r.rd)
						begin
							s_nxt.st = TS_SEND;
							s_nxt.sh = bus.tx_byte;
							s_nxt.drv = ~bus.tx_byte[7];
						end
						else
						begin
							s_nxt.st = TS_RECV;
							s_nxt.drv = 1'b0;
						end
					end
				TS_SEND:
					if (fall)
					begin
						s_nxt.cnt = s_r.cnt + 4'h1;
						s_nxt.sh = {s_r.sh[6:0], 1'b1};
						s_nxt.drv = (s_r.cnt == 4'h7) ? 1'b0 : ~s_r.sh[6];
						if (s_r.cnt == 4'h7)
							s_nxt.st = TS_RACK;
					end
				TS_RACK:
					if (rise)
						s_nxt.st = sda_in ? TS_IDLE : TS_RACK;
					else if (fall)
					begin
						s_nxt.st = TS_SEND;
						s_nxt.cnt = 4'h0;
						s_nxt.sh = bus.tx_byte;
						s_nxt.drv = ~bus.tx_byte[7];
					end
				default: s_nxt.st = TS_IDLE;
			endcase
		end
	end
	// State register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_r <= '{scl_q: 1'b1, sda_q: 1'b1, st: TS_IDLE, default: '0};
		else
			s_r <= s_nxt;
	end
	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe_n = ~s_r.drv;
	assign bus.start = s_r.start;
	assign bus.stop = s_r.stop;
	assign bus.byte_vld = s_r.vld;
	assign bus.rx_byte = s_r.sh;
	assign bus.addr_hit = s_r.hit;
	assign bus.rd_dir = s_r.rd;
	assign bus.first = s_r.first;
endmodule
`default_nettype wire
